// File: rtl/tbs_pkg.sv
// constants for the boundary-scan test access port
// assumes one system clock; the test clock arrives as a plain input pin
package tbs_pkg;

	// tap controller states
	typedef enum logic [3:0] {
		ST_TLR = 4'h0,
		ST_RTI = 4'h1,
		ST_SEL_DR = 4'h2,
		ST_CAP_DR = 4'h3,
		ST_SH_DR = 4'h4,
		ST_EX1_DR = 4'h5,
		ST_PAU_DR = 4'h6,
		ST_EX2_DR = 4'h7,
		ST_UPD_DR = 4'h8,
		ST_SEL_IR = 4'h9,
		ST_CAP_IR = 4'ha,
		ST_SH_IR = 4'hb,
		ST_EX1_IR = 4'hc,
		ST_PAU_IR = 4'hd,
		ST_EX2_IR = 4'he,
		ST_UPD_IR = 4'hf
	} tbs_state_e;

	// data register selected by the current instruction
	typedef enum logic [1:0] {
		SEL_BYP = 2'h0,
		SEL_BSR = 2'h1,
		SEL_ID = 2'h2
	} tbs_sel_e;

	// instruction register
	localparam int IR_W = 4;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
	localparam logic [IR_W-1:0] OP_EXTEST = 4'h0;
	localparam logic [IR_W-1:0] OP_SAMPLE = 4'h1;
	localparam logic [IR_W-1:0] OP_IDCODE = 4'h2;
	localparam logic [IR_W-1:0] OP_HIGHZ = 4'h3;
	localparam logic [IR_W-1:0] OP_BYPASS = 4'hf;

	// identification register fields
	localparam int ID_W = 32;
	localparam logic [3:0] ID_VERSION = 4'h0; // arbitrary value
	localparam logic [15:0] ID_PART = 16'h1234; // arbitrary value
	localparam logic [10:0] ID_MAKER = 11'h055; // arbitrary value
	localparam logic ID_FIXED_ONE = 1'b1;
	localparam logic [ID_W-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, ID_FIXED_ONE};

	// boundary-scan chain length (one cell per scanned pin)
	localparam int BSR_LEN = 8;

	// consecutive tms-high edges that always reach test-logic-reset
	localparam logic [2:0] TLR_TMS_COUNT = 3'h5;

endpackage

// File: rtl/tbs_sync.sv
// two-flop synchroniser for pins outside the system clock domain
// assumes synchronous active-high reset on the system clock
`timescale 1ns/1ps
`default_nettype none
module tbs_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} tbs_sync_s;

	tbs_sync_s cur_ff;
	tbs_sync_s nxt_cur;

	// first stage feeds only the second stage
	always_comb begin
		nxt_cur.s1 = d_i;
		nxt_cur.s2 = cur_ff.s1;
	end

	// register both stages
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign q_o = cur_ff.s2;
endmodule
`default_nettype wire

// File: rtl/tbs_scan_reg.sv
// capture / shift / update register for the instruction and boundary chains
// assumes one-cycle enables derived from test clock edges
`timescale 1ns/1ps
`default_nettype none
module tbs_scan_reg #(
	parameter int W = 4,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic cap_en_i,
	input wire logic shift_en_i,
	input wire logic upd_en_i,
	input wire logic rst_load_i,
	input wire logic [W-1:0] cap_val_i,
	input wire logic si_i,
	output logic [W-1:0] sh_o,
	output logic [W-1:0] upd_o
);
	typedef struct packed {
		logic [W-1:0] sh;
		logic [W-1:0] upd;
	} tbs_scan_s;

	tbs_scan_s cur_ff;
	tbs_scan_s nxt_cur;

	// bit 0 sits nearest the serial output
	always_comb begin
		nxt_cur = cur_ff;
		if (cap_en_i) begin
			nxt_cur.sh = cap_val_i;
		end else if (shift_en_i) begin
			nxt_cur.sh = {si_i, cur_ff.sh[W-1:1]};
		end
		if (rst_load_i) begin
			nxt_cur.upd = RST_VAL;
		end else if (upd_en_i) begin
			nxt_cur.upd = cur_ff.sh;
		end
	end

	// register shift and holding stages
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cur_ff <= {{W{1'b0}}, RST_VAL};
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign sh_o = cur_ff.sh;
	assign upd_o = cur_ff.upd;
endmodule
`default_nettype wire

// File: rtl/tbs_tap.sv
// boundary-scan test access port: tap controller, instruction and data registers
// assumes test pins are asynchronous to clk_i and the test clock is far slower
`timescale 1ns/1ps
`default_nettype none
module tbs_tap (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	input wire logic trst_n_i,
	input wire logic [tbs_pkg::BSR_LEN-1:0] pin_sample_i,
	output logic tdo_o,
	output logic tdo_oe_o,
	output logic [tbs_pkg::BSR_LEN-1:0] bsr_drive_o,
	output logic extest_o,
	output logic outs_off_o,
	output logic tap_ready_o
);
	import tbs_pkg::*;

	typedef struct packed {
		tbs_state_e state;
		logic tck_d;
		logic byp;
		logic [ID_W-1:0] id_sh;
		logic tdo;
		logic tdo_oe;
		logic extest;
		logic outs_off;
		logic ready;
		logic [2:0] tms_ones;
	} tbs_tap_s;

	tbs_tap_s cur_ff;
	tbs_tap_s nxt_cur;

	logic tck_s;
	logic tms_s;
	logic tdi_s;
	logic trst_n_s;
	logic tck_rise;
	logic tck_fall;
	logic [IR_W-1:0] ir_sh;
	logic [IR_W-1:0] ir_cur;
	logic [BSR_LEN-1:0] bsr_sh;
	tbs_sel_e dr_sel;
	logic dr_out;

	// next tap state from the sampled tms level; five tms-high edges reach reset from any state
	function automatic tbs_state_e tap_next(input tbs_state_e st, input logic tms);
		tbs_state_e nx;
		nx = st;
		case (st)
			ST_TLR: nx = tms ? ST_TLR : ST_RTI;
			ST_RTI: nx = tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_DR: nx = tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: nx = tms ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR: nx = tms ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: nx = tms ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: nx = tms ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: nx = tms ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: nx = tms ? ST_SEL_DR : ST_RTI;
			ST_SEL_IR: nx = tms ? ST_TLR : ST_CAP_IR;
			ST_CAP_IR: nx = tms ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR: nx = tms ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: nx = tms ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: nx = tms ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: nx = tms ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: nx = tms ? ST_SEL_DR : ST_RTI;
			default: nx = ST_TLR;
		endcase
		return nx;
	endfunction

	// data register chosen by an instruction code
	function automatic tbs_sel_e dr_decode(input logic [IR_W-1:0] op);
		tbs_sel_e sel;
		if (op == OP_EXTEST || op == OP_SAMPLE) begin
			sel = SEL_BSR;
		end else if (op == OP_IDCODE) begin
			sel = SEL_ID;
		end else begin
			sel = SEL_BYP; // highz, bypass and unassigned codes
		end
		return sel;
	endfunction

	// all four test inputs cross into the system clock domain
	tbs_sync #(
		.W(4)
	) u_sync (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.d_i({tck_i, tms_i, tdi_i, trst_n_i}),
		.q_o({tck_s, tms_s, tdi_s, trst_n_s})
	);

	// test clock edges found from the synchronised level
	assign tck_rise = tck_s & ~cur_ff.tck_d;
	assign tck_fall = ~tck_s & cur_ff.tck_d;
	assign dr_sel = dr_decode(ir_cur);

	// instruction register: 4 bits, captures 0001, idcode after reset
	tbs_scan_reg #(
		.W(IR_W),
		.RST_VAL(OP_IDCODE)
	) u_ir (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.cap_en_i(tck_rise && cur_ff.state == ST_CAP_IR),
		.shift_en_i(tck_rise && cur_ff.state == ST_SH_IR),
		.upd_en_i(tck_fall && cur_ff.state == ST_UPD_IR),
		.rst_load_i(cur_ff.state == ST_TLR),
		.cap_val_i(IR_CAPTURE),
		.si_i(tdi_s),
		.sh_o(ir_sh),
		.upd_o(ir_cur)
	);

	// boundary chain: samples pins, holds values to drive under extest
	tbs_scan_reg #(
		.W(BSR_LEN),
		.RST_VAL('0)
	) u_bsr (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.cap_en_i(tck_rise && cur_ff.state == ST_CAP_DR && dr_sel == SEL_BSR),
		.shift_en_i(tck_rise && cur_ff.state == ST_SH_DR && dr_sel == SEL_BSR),
		.upd_en_i(tck_fall && cur_ff.state == ST_UPD_DR && dr_sel == SEL_BSR),
		.rst_load_i(1'b0),
		.cap_val_i(pin_sample_i),
		.si_i(tdi_s),
		.sh_o(bsr_sh),
		.upd_o(bsr_drive_o)
	);

	// common serial output of the three data registers
	always_comb begin
		case (dr_sel)
			SEL_BSR: dr_out = bsr_sh[0];
			SEL_ID: dr_out = cur_ff.id_sh[0];
			default: dr_out = cur_ff.byp;
		endcase
	end

	// controller, data registers, tdo and mode outputs
	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.tck_d = tck_s;
		if (tck_rise) begin
			// capture and shift act in the state being left
			if (cur_ff.state == ST_CAP_DR) begin
				if (dr_sel == SEL_BYP) begin
					nxt_cur.byp = 1'b0;
				end
				if (dr_sel == SEL_ID) begin
					nxt_cur.id_sh = ID_VALUE;
				end
			end else if (cur_ff.state == ST_SH_DR) begin
				if (dr_sel == SEL_BYP) begin
					nxt_cur.byp = tdi_s;
				end
				if (dr_sel == SEL_ID) begin
					nxt_cur.id_sh = {tdi_s, cur_ff.id_sh[ID_W-1:1]};
				end
			end
			// the sampled tms picks the next state unless the test reset pin is low
			nxt_cur.state = tap_next(cur_ff.state, tms_s);
			// helper count of consecutive tms-high edges
			if (!tms_s) begin
				nxt_cur.tms_ones = 3'h0;
			end else if (cur_ff.tms_ones != TLR_TMS_COUNT) begin
				nxt_cur.tms_ones = cur_ff.tms_ones + 3'h1;
			end
		end
		// tdo changes on the falling test clock edge
		if (tck_fall) begin
			nxt_cur.tdo_oe = (cur_ff.state == ST_SH_IR) || (cur_ff.state == ST_SH_DR);
			nxt_cur.tdo = (cur_ff.state == ST_SH_IR) ? ir_sh[0] : dr_out;
		end
		// mode outputs follow the current instruction in every state but test-logic-reset, run-test-idle included
		nxt_cur.extest = (cur_ff.state != ST_TLR) && (ir_cur == OP_EXTEST);
		nxt_cur.outs_off = (cur_ff.state != ST_TLR) && (ir_cur == OP_HIGHZ);
		// tap must see test-logic-reset before queue operation is allowed
		if (cur_ff.state == ST_TLR) begin
			nxt_cur.ready = 1'b1;
		end
		// test reset pin overrides the tms-driven next state and the tms count
		if (!trst_n_s) begin
			nxt_cur.state = ST_TLR;
			nxt_cur.tms_ones = 3'h0;
		end
		if (nxt_cur.state == ST_TLR) begin
			nxt_cur.extest = 1'b0;
			nxt_cur.outs_off = 1'b0;
		end
	end

	// register the whole state
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cur_ff.state <= ST_TLR;
			cur_ff.tck_d <= 1'b0;
			cur_ff.byp <= 1'b0;
			cur_ff.id_sh <= '0;
			cur_ff.tdo <= 1'b0;
			cur_ff.tdo_oe <= 1'b0;
			cur_ff.extest <= 1'b0;
			cur_ff.outs_off <= 1'b0;
			cur_ff.ready <= 1'b0;
			cur_ff.tms_ones <= 3'h0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// outputs straight from flops
	assign tdo_o = cur_ff.tdo;
	assign tdo_oe_o = cur_ff.tdo_oe;
	assign extest_o = cur_ff.extest;
	assign outs_off_o = cur_ff.outs_off;
	assign tap_ready_o = cur_ff.ready;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	// checks
	a_tms_five_reset: assert property (
		tck_rise && tms_s && cur_ff.tms_ones >= 3'h4 |=> cur_ff.state == ST_TLR)
		else $error("five tms-high edges did not reach test-logic-reset");
	a_trst_forces_tlr: assert property (
		!trst_n_s |=> cur_ff.state == ST_TLR)
		else $error("test reset pin did not force test-logic-reset");
	a_state_rise_only: assert property (
		!tck_rise && trst_n_s |=> $stable(cur_ff.state))
		else $error("tap state moved without a test clock rise");
	a_capture_ir_pattern: assert property (
		tck_rise && cur_ff.state == ST_CAP_IR |=> ir_sh[1:0] == 2'b01)
		else $error("capture-ir pattern lsbs not 01");
	a_ir_update_fall: assert property (
		tck_fall && cur_ff.state == ST_UPD_IR |=> ir_cur == $past(ir_sh))
		else $error("instruction not latched on falling edge");
	a_tlr_idcode_load: assert property (
		cur_ff.state == ST_TLR |=> ir_cur == OP_IDCODE && !extest_o && !outs_off_o)
		else $error("test logic active in test-logic-reset");
	a_bypass_zero: assert property (
		tck_rise && cur_ff.state == ST_CAP_DR && dr_sel == SEL_BYP |=> cur_ff.byp == 1'b0)
		else $error("bypass stage did not capture zero");
	a_idcode_capture: assert property (
		tck_rise && cur_ff.state == ST_CAP_DR && dr_sel == SEL_ID |=> cur_ff.id_sh == ID_VALUE)
		else $error("identification value not captured");
	a_highz_outputs: assert property (
		ir_cur == OP_HIGHZ && cur_ff.state != ST_TLR ##1 cur_ff.state != ST_TLR
		|-> outs_off_o)
		else $error("highz instruction did not disable outputs");
	a_tdo_shift_only: assert property (
		tck_fall && (cur_ff.state == ST_SH_IR || cur_ff.state == ST_SH_DR) |=> tdo_oe_o)
		else $error("tdo not enabled while shifting");
	a_unknown_bypass: assert property (
		ir_cur inside {[4'h4:4'he]} ##1 ir_cur inside {[4'h4:4'he]}
		|-> dr_sel == SEL_BYP && !extest_o && !outs_off_o)
		else $error("unassigned code did not select bypass");

	// controller branch and ready checks
	a_sel_dr_branch: assert property (
		tck_rise && trst_n_s && cur_ff.state == ST_SEL_DR
		|=> cur_ff.state == ($past(tms_s) ? ST_SEL_IR : ST_CAP_DR))
		else $error("select-dr-scan took the wrong branch");
	a_sel_ir_exit: assert property (
		tck_rise && cur_ff.state == ST_SEL_IR && tms_s |=> cur_ff.state == ST_TLR)
		else $error("select-ir-scan did not return to test-logic-reset");
	a_ready_sticky: assert property (
		tap_ready_o |=> tap_ready_o)
		else $error("queue permission dropped after tap reset");

	// instruction path checks
	a_pause_ir_hold: assert property (
		cur_ff.state == ST_PAU_IR |=> $stable(ir_sh))
		else $error("instruction shift stage moved in pause-ir");
	a_tdo_ir_lsb: assert property (
		tck_fall && cur_ff.state == ST_SH_IR |=> tdo_o == $past(ir_sh[0]))
		else $error("tdo did not show instruction lsb in shift-ir");
	a_ir_shift_in: assert property (
		tck_rise && cur_ff.state == ST_SH_IR |=> ir_sh[IR_W-1] == $past(tdi_s))
		else $error("tdi not shifted into instruction stage");

	// data path checks
	a_tdo_dr_path: assert property (
		tck_fall && cur_ff.state == ST_SH_DR |=> tdo_o == $past(dr_out))
		else $error("tdo did not follow the selected data register");
	a_bsr_capture: assert property (
		tck_rise && cur_ff.state == ST_CAP_DR && dr_sel == SEL_BSR |=> bsr_sh == $past(pin_sample_i))
		else $error("boundary chain did not capture the pins");
	a_bsr_update_fall: assert property (
		tck_fall && cur_ff.state == ST_UPD_DR && dr_sel == SEL_BSR |=> bsr_drive_o == $past(bsr_sh))
		else $error("boundary update stage not loaded on falling edge");
	a_id_shift_in: assert property (
		tck_rise && cur_ff.state == ST_SH_DR && dr_sel == SEL_ID |=> cur_ff.id_sh[ID_W-1] == $past(tdi_s))
		else $error("tdi not shifted into identification register");

	// mode output checks
	a_bypass_no_mode: assert property (
		ir_cur == OP_BYPASS ##1 ir_cur == OP_BYPASS |-> !extest_o && !outs_off_o)
		else $error("bypass instruction disturbed normal operation");
	a_extest_mode: assert property (
		ir_cur == OP_EXTEST && cur_ff.state != ST_TLR ##1 cur_ff.state != ST_TLR
		|-> extest_o)
		else $error("extest instruction did not raise its mode output");

	// main scenario coverage

	c_ir_update: cover property (tck_fall && cur_ff.state == ST_UPD_IR);
	c_id_shift: cover property (tck_rise && cur_ff.state == ST_SH_DR && dr_sel == SEL_ID);
	c_extest_on: cover property (extest_o);
	c_pause_dr: cover property (tck_rise && cur_ff.state == ST_PAU_DR);
	c_highz_on: cover property (outs_off_o);
endmodule
`default_nettype wire

// File: tb/tbs_tester.sv
// test controller model: drives the test pins and reads test data out
// assumes the device samples these pins with its own fast clock
`timescale 1ns/1ps
`default_nettype none
module tbs_tester (
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o,
	output logic trst_n_o,
	input wire logic tdo_i
);
	// idle pins; the test clock stands low between frames
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b1;
		trst_n_o = 1'b1;
	end
	// one 125 ns test clock period; tdo is read well after the fall
	// pins move a quarter or half a nanosecond off the system clock grid, never on an edge
	task automatic cycle(input logic tms, input logic tdi, output logic tdo);
		#0.5 tms_o = tms;
		tdi_o = tdi;
		#31.25 tck_o = 1'b1;
		#62.5 tck_o = 1'b0;
		#30.25 tdo = tdo_i;
		#0.5;
	endtask
	// reset pin pulse, longer than the minimum low time, then recovery
	task automatic trst_pulse();
		#0.5 trst_n_o = 1'b0;
		#60 trst_n_o = 1'b1;
		#59.5;
	endtask
endmodule
`default_nettype wire

// File: tb/boundary_scan_tap_controller_tb_top.sv
// self-checking bench for the test access port with a reference tap model
// assumes tbs_tester on the test pins and a 250 mhz system clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
	$display("wrong value %s exp %h got %h", nm, e, g); end end
module boundary_scan_tap_controller_tb_top;
	import tbs_pkg::*;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic tck, tms, tdi, trst_n, sb;
	logic [BSR_LEN-1:0] pin_sample_i = '0;
	logic [BSR_LEN-1:0] bsr_drive_o;
	logic [BSR_LEN-1:0] drv_exp = '0;
	logic tdo_o, tdo_oe_o, extest_o, outs_off_o, tap_ready_o;
	logic [31:0] din, dout, expv;
	int failures = 0;
	int num_checks = 0;
	int cycles = 0;
	int ms = 0;
	int len, code, k;
	// reference next state for tms low and tms high
	int n0[16] = '{1, 1, 3, 4, 4, 6, 6, 4, 1, 10, 11, 11, 13, 13, 11, 1};
	int n1[16] = '{0, 2, 9, 5, 5, 8, 7, 8, 2, 0, 12, 12, 15, 14, 15, 2};

	always #2 clk_i = ~clk_i;

	tbs_tester tester (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n), .tdo_i(tdo_o));

	tbs_tap uut (
		.clk_i(clk_i), .reset_i(reset_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n),
		.pin_sample_i(pin_sample_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .bsr_drive_o(bsr_drive_o),
		.extest_o(extest_o), .outs_off_o(outs_off_o), .tap_ready_o(tap_ready_o));

	// hang guard
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 60000) begin
			failures++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// one test clock with the model stepped alongside
	task automatic go(input logic t, input logic d, output logic s);
		tester.cycle(t, d, s);
		ms = t ? n1[ms] : n0[ms];
		`CHK("tdo_oe_o", logic'(ms == 4 || ms == 11), tdo_oe_o)
	endtask

	// full scan from run-test-idle, lsb first, optional pause after bit pz
	task automatic scan(input logic ir, input int n, input logic [31:0] d, input int pz, output logic [31:0] q);
		logic s;
		q = '0;
		go(1'b1, 1'b0, s);
		if (ir) begin
			go(1'b1, 1'b0, s);
		end
		go(1'b0, 1'b0, s);
		go(1'b0, 1'b0, s);
		q[0] = s;
		for (int i = 0; i < n; i++) begin
			go(logic'(i == n - 1 || i == pz), d[i], s);
			if (i == pz && i < n - 1) begin
				go(1'b0, 1'b0, s);
				go(1'b0, 1'b0, s);
				go(1'b1, 1'b0, s);
				go(1'b0, 1'b0, s);
			end
			if (i < n - 1) begin
				q[i + 1] = s;
			end
		end
		go(1'b1, 1'b0, s);
		go(1'b0, 1'b0, s);
	endtask

	// serial output of a register of length l holding capture value c
	function automatic logic [31:0] shifted(input int l, input logic [31:0] c, input logic [31:0] d);
		logic [31:0] r;
		for (int j = 0; j < 32; j++) begin
			r[j] = (j < l) ? c[j] : d[j - l];
		end
		return r;
	endfunction

	task automatic ir_load(input int c);
		scan(1'b1, IR_W, 32'(c), $urandom_range(0, IR_W - 1), dout);
		`CHK("ir capture", IR_CAPTURE, dout[IR_W-1:0])
		`CHK("extest_o", logic'(c == 0), extest_o)
		`CHK("outs_off_o", logic'(c == 3), outs_off_o)
	endtask

	// data scan of 32 bits through the register that code c selects
	task automatic dr_test(input int c);
		@(posedge clk_i);
		#1 pin_sample_i = BSR_LEN'($urandom);
		din = $urandom;
		len = (c < 2) ? BSR_LEN : (c == 2) ? ID_W : 1;
		expv = shifted(len, (c < 2) ? 32'(pin_sample_i) : (c == 2) ? ID_VALUE : 32'h0, din);
		scan(1'b0, 32, din, $urandom_range(0, 31), dout);
		`CHK("dr scan", expv, dout)
		if (c < 2) begin
			drv_exp = din[31 -: BSR_LEN];
		end
		if (c != 2) begin
			`CHK("bsr_drive_o", drv_exp, bsr_drive_o)
		end
	endtask

	// after a tap reset: modes off and identification readable at once
	task automatic tlr_check();
		`CHK("extest_o", 1'b0, extest_o)
		`CHK("outs_off_o", 1'b0, outs_off_o)
		go(1'b0, 1'b0, sb);
		dr_test(2);
	endtask

	// main sequence
	initial begin
		k = $urandom(32'he2347d17);
		repeat (4) @(posedge clk_i);
		#1 reset_i = 1'b0;
		for (k = 0; k < 10 && tap_ready_o !== 1'b1; k++) begin
			@(posedge clk_i);
			#1;
		end
		`CHK("tap_ready_o", 1'b1, tap_ready_o)
		`CHK("bsr_drive_o", drv_exp, bsr_drive_o)
		repeat (4) @(posedge clk_i);
		repeat (5) go(1'b1, 1'b0, sb);
		go(1'b0, 1'b0, sb);
		for (code = 0; code < 16; code++) begin
			ir_load(code);
			dr_test(code);
		end
		ir_load(0);
		tester.trst_pulse();
		ms = 0;
		tlr_check();
		ir_load(0);
		for (k = 0; k < 20; k++) begin
			go(1'($urandom), 1'($urandom), sb);
		end
		repeat (5) go(1'b1, 1'b0, sb);
		tlr_check();
		tally_and_finish();
	end
endmodule
`default_nettype wire
